// [itx_pkg.sv]
// Shared constants for the interrupt, timer and transfer instruction unit
package itx_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned NIB_W   = 4;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned INSTR_W = 10;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [INSTR_W-1:0] OP_RET_IRQ      = 10'h046;
    localparam logic [INSTR_W-1:0] OP_RET_SUB      = 10'h044;
    localparam logic [INSTR_W-1:0] OP_RET_SUB_SKIP = 10'h045;
    localparam logic [INSTR_W-1:0] OP_IRQ_DIS      = 10'h004;
    localparam logic [INSTR_W-1:0] OP_IRQ_ENA      = 10'h005;
    localparam logic [INSTR_W-1:0] OP_TST_FLAG0    = 10'h038;
    localparam logic [INSTR_W-1:0] OP_TST_FLAG1    = 10'h039;
    localparam logic [INSTR_W-1:0] OP_TST_PIN0     = 10'h03a;
    localparam logic [INSTR_W-1:0] OP_TST_PIN1     = 10'h03b;
    localparam logic [INSTR_W-1:0] OP_RD_ICTRL1    = 10'h254;
    localparam logic [INSTR_W-1:0] OP_WR_ICTRL1    = 10'h23c;
    localparam logic [INSTR_W-1:0] OP_RD_ICTRL2    = 10'h255;
    localparam logic [INSTR_W-1:0] OP_WR_ICTRL2    = 10'h23d;
    localparam logic [INSTR_W-1:0] OP_RD_ECTRL1    = 10'h253;
    localparam logic [INSTR_W-1:0] OP_WR_ECTRL1    = 10'h217;
    localparam logic [INSTR_W-1:0] OP_RD_ECTRL2    = 10'h252;
    localparam logic [INSTR_W-1:0] OP_WR_ECTRL2    = 10'h218;
    localparam logic [INSTR_W-1:0] OP_WR_PSCTRL    = 10'h22b;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL1    = 10'h24b;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL1    = 10'h20e;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL2    = 10'h24c;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL2    = 10'h20f;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL3    = 10'h24d;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL3    = 10'h210;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL4    = 10'h24e;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL4    = 10'h211;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL5    = 10'h24f;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL5    = 10'h212;
    localparam logic [INSTR_W-1:0] OP_RD_TCTRL6    = 10'h250;
    localparam logic [INSTR_W-1:0] OP_WR_TCTRL6    = 10'h213;
    localparam logic [INSTR_W-1:0] READ_PRESCALER_OP    = 10'h275;
    localparam logic [INSTR_W-1:0] WRITE_PRESCALER_OP   = 10'h235;
    localparam logic [INSTR_W-1:0] OP_RD_TIMER_BASE     = 10'h270;
    localparam logic [INSTR_W-1:0] OP_WR_TIMER_BASE     = 10'h230;
    localparam logic [INSTR_W-1:0] HIGH_RELOAD_WRITE_OP = 10'h237;
    localparam logic [INSTR_W-1:0] RELOAD_ONLY_WRITE_OP = 10'h23f;
    localparam logic [INSTR_W-1:0] OP_RELOAD_ONLY_T3    = 10'h23b;
    localparam logic [INSTR_W-1:0] RELOAD_COPY_OP       = 10'h297;

    // ------------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------------
    localparam int unsigned EXT0_IRQ_ENABLE_BIT = 0;
    localparam int unsigned EXT1_IRQ_ENABLE_BIT = 1;
    localparam int unsigned PIN_POLARITY_BIT    = 2;

    // ------------------------------------------------------------------
    // APB register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_ACC     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TCTRL   = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_PRESC   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_TIMER1  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TIMER2  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_TIMER3  = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_TIMER4  = 8'h20;

    // STATUS field positions
    localparam int unsigned ST_GIE  = 0;
    localparam int unsigned ST_EXT0 = 1;
    localparam int unsigned ST_EXT1 = 2;
    localparam int unsigned ST_SKIP = 3;

endpackage : itx_pkg

// [itx_exec.sv]
// Execution unit for interrupt, timer-register and transfer instructions
//
// Behaviour
// [RULE1] Interrupt return restores pointers, carry, skip, nop mode, A and B
// [RULE2] Both subroutine returns resume caller; skipping return skips next instruction
// [RULE3] Interrupt-disable clears the global interrupt enable flag
// [RULE4] Interrupt-enable sets the global interrupt enable flag
// [RULE5] External-0 test: enabled bit clear, skip and clear flag if set
// [RULE6] External-1 test: enabled bit clear, skip and clear flag if set
// [RULE7] Pin 0 test skips on level matching first edge control bit 2
// [RULE8] Pin 1 test skips on level matching second edge control bit 2
// [RULE9] A reads and writes both interrupt and both edge control registers
// [RULE10] Prescaler control is write-only from A
// [RULE11] A reads and writes timer control registers one to four
// [RULE12] Timer control five and six transfers with their fixed codes
// [RULE13] Prescaler read: upper nibble to B, lower nibble to A
// [RULE14] Prescaler write loads count and reload together from B and A
// [RULE15] Timer reads one to four put upper nibble in B, lower in A
// [RULE16] Timer writes one to three load count and reload from B, A
// [RULE17] Timer four write loads count and low reload
// [RULE18] High reload write touches only timer four high reload
// [RULE19] Reload-only writes for timers one and three keep count
// [RULE20] Reload copy moves timer four low reload into timer four count
// [RULE21] Every instruction is one word, one cycle; bytes split B high, A low
// [RULE22] A skipped instruction is fetched but suppressed
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module itx_exec
    import itx_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    // Instruction stream from the core
    input  wire logic                  instr_valid_i,
    input  wire logic [INSTR_W-1:0]    instr_i,
    // Interrupt entry snapshot inputs
    input  wire logic                  irq_entry_i,
    input  wire logic [NIB_W-1:0]      dp_x_i,
    input  wire logic [NIB_W-1:0]      dp_y_i,
    input  wire logic [1:0]            dp_z_i,
    input  wire logic                  carry_i,
    input  wire logic                  nop_mode_i,
    // External request events and pins
    input  wire logic                  ext0_req_i,
    input  wire logic                  ext1_req_i,
    input  wire logic                  ext_irq_pin_zero_i,
    input  wire logic                  ext_irq_pin_one_i,
    // Core side results
    output logic                       global_irq_enable_flag_o,
    output logic                       skip_o,
    output logic                       ret_sub_o,
    output logic                       ret_irq_o,
    output logic [NIB_W-1:0]           restore_x_o,
    output logic [NIB_W-1:0]           restore_y_o,
    output logic [1:0]                 restore_z_o,
    output logic                       restore_carry_o,
    output logic                       restore_nop_mode_o,
    output logic [NIB_W-1:0]           acc_a_o,
    output logic [NIB_W-1:0]           acc_b_o,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [ADDR_W-1:0]     paddr_i,
    input  wire logic [DATA_W-1:0]     pwdata_i,
    output logic [DATA_W-1:0]          prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NIB_W-1:0]   acc_a;
        logic [NIB_W-1:0]   acc_b;
        logic               gie;
        logic               ext0_request_flag;
        logic               ext1_request_flag;
        logic               skip;
        logic [NIB_W-1:0]   irq_ctrl_first;
        logic [NIB_W-1:0]   irq_ctrl_second;
        logic [NIB_W-1:0]   edge_ctrl_first;
        logic [NIB_W-1:0]   edge_ctrl_second;
        logic [NIB_W-1:0]   prescaler_ctrl;
        logic [5:0][NIB_W-1:0] timer_ctrl;
        logic [BYTE_W-1:0]  prescaler_count;
        logic [BYTE_W-1:0]  prescaler_reload;
        logic [3:0][BYTE_W-1:0] timer_count;
        logic [2:0][BYTE_W-1:0] timer_reload;
        logic [BYTE_W-1:0]  timer_four_low_reload;
        logic [BYTE_W-1:0]  timer_four_high_reload;
        logic [NIB_W-1:0]   sv_x;
        logic [NIB_W-1:0]   sv_y;
        logic [1:0]         sv_z;
        logic               sv_carry;
        logic               sv_nop;
        logic               sv_skip;
        logic [NIB_W-1:0]   sv_a;
        logic [NIB_W-1:0]   sv_b;
        logic               ret_sub;
        logic               ret_irq;
        logic               pin0_meta;
        logic               pin0_sync;
        logic               pin1_meta;
        logic               pin1_sync;
        logic [DATA_W-1:0]  rdata;
        logic               bus_err;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic               exec;
    logic               set_skip;
    logic               apb_setup;
    logic               apb_access;
    logic               addr_hit;
    logic [DATA_W-1:0]  rd_mux;
    logic [1:0]         tsel;

    // ------------------------------------------------------------------
    // APB read decode
    // ------------------------------------------------------------------
    // Read mux of mapped registers, unmapped reads return zero
    always_comb
    begin
        addr_hit = 1'b1;
        rd_mux   = '0;
        unique case (paddr_i)
            REG_ACC:    rd_mux = {24'h000000, state_q.acc_b, state_q.acc_a};
            REG_STATUS: rd_mux = {28'h0000000, state_q.skip,
                                  state_q.ext1_request_flag,
                                  state_q.ext0_request_flag, state_q.gie};
            REG_CTRL:   rd_mux = {12'h000, state_q.prescaler_ctrl,
                                  state_q.edge_ctrl_second, state_q.edge_ctrl_first,
                                  state_q.irq_ctrl_second, state_q.irq_ctrl_first};
            REG_TCTRL:  rd_mux = {8'h00, state_q.timer_ctrl};
            REG_PRESC:  rd_mux = {16'h0000, state_q.prescaler_reload,
                                  state_q.prescaler_count};
            REG_TIMER1: rd_mux = {16'h0000, state_q.timer_reload[0],
                                  state_q.timer_count[0]};
            REG_TIMER2: rd_mux = {16'h0000, state_q.timer_reload[1],
                                  state_q.timer_count[1]};
            REG_TIMER3: rd_mux = {16'h0000, state_q.timer_reload[2],
                                  state_q.timer_count[2]};
            REG_TIMER4: rd_mux = {8'h00, state_q.timer_four_high_reload,
                                  state_q.timer_four_low_reload,
                                  state_q.timer_count[3]};
            default:
            begin
                addr_hit = 1'b0;
                rd_mux   = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        tsel    = instr_i[1:0];

        // Pin synchronisers, first stage feeds only the second
        state_d.pin0_meta = ext_irq_pin_zero_i;
        state_d.pin0_sync = state_q.pin0_meta;
        state_d.pin1_meta = ext_irq_pin_one_i;
        state_d.pin1_sync = state_q.pin1_meta;

        state_d.ret_sub = 1'b0;
        state_d.ret_irq = 1'b0;

        // Suppressed instruction consumes the skip and nothing else
        exec     = instr_valid_i & ~state_q.skip;  // see [RULE22]
        set_skip = 1'b0;
        if (instr_valid_i && state_q.skip)
        begin
            state_d.skip = 1'b0;  // see [RULE22]
        end

        // Snapshot taken on interrupt entry
        if (irq_entry_i)
        begin
            state_d.sv_x     = dp_x_i;
            state_d.sv_y     = dp_y_i;
            state_d.sv_z     = dp_z_i;
            state_d.sv_carry = carry_i;
            state_d.sv_nop   = nop_mode_i;
            state_d.sv_skip  = state_q.skip;
            state_d.sv_a     = state_q.acc_a;
            state_d.sv_b     = state_q.acc_b;
        end

        // One word, one cycle execution
        if (exec)  // see [RULE21]
        begin
            case (instr_i)
                OP_RET_IRQ:
                begin
                    state_d.ret_irq = 1'b1;  // see [RULE1]
                    state_d.acc_a   = state_q.sv_a;
                    state_d.acc_b   = state_q.sv_b;
                    set_skip        = state_q.sv_skip;  // see [RULE1]
                end
                OP_RET_SUB:      state_d.ret_sub = 1'b1;  // see [RULE2]
                OP_RET_SUB_SKIP:
                begin
                    state_d.ret_sub = 1'b1;
                    set_skip        = 1'b1;  // see [RULE2]
                end
                OP_IRQ_DIS:      state_d.gie = 1'b0;  // see [RULE3]
                OP_IRQ_ENA:      state_d.gie = 1'b1;  // see [RULE4]
                OP_TST_FLAG0:
                begin
                    if (!state_q.irq_ctrl_first[EXT0_IRQ_ENABLE_BIT]
                        && state_q.ext0_request_flag)
                    begin
                        set_skip                  = 1'b1;  // see [RULE5]
                        state_d.ext0_request_flag = 1'b0;
                    end
                end
                OP_TST_FLAG1:
                begin
                    if (!state_q.irq_ctrl_first[EXT1_IRQ_ENABLE_BIT]
                        && state_q.ext1_request_flag)
                    begin
                        set_skip                  = 1'b1;  // see [RULE6]
                        state_d.ext1_request_flag = 1'b0;
                    end
                end
                OP_TST_PIN0:
                    set_skip = ~(state_q.pin0_sync
                               ^ state_q.edge_ctrl_first[PIN_POLARITY_BIT]);  // see [RULE7]
                OP_TST_PIN1:
                    set_skip = ~(state_q.pin1_sync
                               ^ state_q.edge_ctrl_second[PIN_POLARITY_BIT]);  // see [RULE8]
                OP_RD_ICTRL1: state_d.acc_a = state_q.irq_ctrl_first;    // see [RULE9]
                OP_WR_ICTRL1: state_d.irq_ctrl_first = state_q.acc_a;    // see [RULE9]
                OP_RD_ICTRL2: state_d.acc_a = state_q.irq_ctrl_second;   // see [RULE9]
                OP_WR_ICTRL2: state_d.irq_ctrl_second = state_q.acc_a;   // see [RULE9]
                OP_RD_ECTRL1: state_d.acc_a = state_q.edge_ctrl_first;   // see [RULE9]
                OP_WR_ECTRL1: state_d.edge_ctrl_first = state_q.acc_a;   // see [RULE9]
                OP_RD_ECTRL2: state_d.acc_a = state_q.edge_ctrl_second;  // see [RULE9]
                OP_WR_ECTRL2: state_d.edge_ctrl_second = state_q.acc_a;  // see [RULE9]
                OP_WR_PSCTRL: state_d.prescaler_ctrl = state_q.acc_a;    // see [RULE10]
                OP_RD_TCTRL1: state_d.acc_a = state_q.timer_ctrl[0];     // see [RULE11]
                OP_WR_TCTRL1: state_d.timer_ctrl[0] = state_q.acc_a;     // see [RULE11]
                OP_RD_TCTRL2: state_d.acc_a = state_q.timer_ctrl[1];     // see [RULE11]
                OP_WR_TCTRL2: state_d.timer_ctrl[1] = state_q.acc_a;     // see [RULE11]
                OP_RD_TCTRL3: state_d.acc_a = state_q.timer_ctrl[2];     // see [RULE11]
                OP_WR_TCTRL3: state_d.timer_ctrl[2] = state_q.acc_a;     // see [RULE11]
                OP_RD_TCTRL4: state_d.acc_a = state_q.timer_ctrl[3];     // see [RULE11]
                OP_WR_TCTRL4: state_d.timer_ctrl[3] = state_q.acc_a;     // see [RULE11]
                OP_RD_TCTRL5: state_d.acc_a = state_q.timer_ctrl[4];     // see [RULE12]
                OP_WR_TCTRL5: state_d.timer_ctrl[4] = state_q.acc_a;     // see [RULE12]
                OP_RD_TCTRL6: state_d.acc_a = state_q.timer_ctrl[5];     // see [RULE12]
                OP_WR_TCTRL6: state_d.timer_ctrl[5] = state_q.acc_a;     // see [RULE12]
                READ_PRESCALER_OP:
                    {state_d.acc_b, state_d.acc_a} = state_q.prescaler_count;  // see [RULE13]
                WRITE_PRESCALER_OP:
                begin
                    state_d.prescaler_count  = {state_q.acc_b, state_q.acc_a};  // see [RULE14]
                    state_d.prescaler_reload = {state_q.acc_b, state_q.acc_a};
                end
                OP_RD_TIMER_BASE, OP_RD_TIMER_BASE + 10'h001,
                OP_RD_TIMER_BASE + 10'h002, OP_RD_TIMER_BASE + 10'h003:
                    {state_d.acc_b, state_d.acc_a} = state_q.timer_count[tsel];  // see [RULE15]
                OP_WR_TIMER_BASE, OP_WR_TIMER_BASE + 10'h001,
                OP_WR_TIMER_BASE + 10'h002:
                begin
                    state_d.timer_count[tsel]  = {state_q.acc_b, state_q.acc_a};  // see [RULE16]
                    state_d.timer_reload[tsel] = {state_q.acc_b, state_q.acc_a};
                end
                OP_WR_TIMER_BASE + 10'h003:
                begin
                    state_d.timer_count[3]  = {state_q.acc_b, state_q.acc_a};  // see [RULE17]
                    state_d.timer_four_low_reload = {state_q.acc_b, state_q.acc_a};
                end
                HIGH_RELOAD_WRITE_OP:
                    state_d.timer_four_high_reload = {state_q.acc_b, state_q.acc_a};  // see [RULE18]
                RELOAD_ONLY_WRITE_OP:
                    state_d.timer_reload[0] = {state_q.acc_b, state_q.acc_a};  // see [RULE19]
                OP_RELOAD_ONLY_T3:
                    state_d.timer_reload[2] = {state_q.acc_b, state_q.acc_a};  // see [RULE19]
                RELOAD_COPY_OP:
                    state_d.timer_count[3] = state_q.timer_four_low_reload;  // see [RULE20]
                default: ;
            endcase
        end
        if (set_skip)
        begin
            state_d.skip = 1'b1;
        end

        // APB setup phase latches read data and error, access phase writes
        apb_setup  = psel_i & ~penable_i;
        apb_access = psel_i & penable_i;
        if (apb_setup)
        begin
            state_d.rdata   = rd_mux;
            state_d.bus_err = ~addr_hit;
        end
        if (apb_access && pwrite_i && addr_hit)
        begin
            if (paddr_i == REG_ACC)
            begin
                state_d.acc_a = pwdata_i[NIB_W-1:0];
                state_d.acc_b = pwdata_i[2*NIB_W-1:NIB_W];
            end
            if (paddr_i == REG_STATUS)
            begin
                if (pwdata_i[ST_EXT0])
                begin
                    state_d.ext0_request_flag = 1'b0;
                end
                if (pwdata_i[ST_EXT1])
                begin
                    state_d.ext1_request_flag = 1'b0;
                end
            end
        end

        // Hardware set wins over any clear in the same cycle
        if (ext0_req_i)
        begin
            state_d.ext0_request_flag = 1'b1;
        end
        if (ext1_req_i)
        begin
            state_d.ext1_request_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign global_irq_enable_flag_o = state_q.gie;
    assign skip_o                   = state_q.skip;
    assign ret_sub_o                = state_q.ret_sub;
    assign ret_irq_o                = state_q.ret_irq;
    assign restore_x_o              = state_q.sv_x;  // see [RULE1]
    assign restore_y_o              = state_q.sv_y;
    assign restore_z_o              = state_q.sv_z;
    assign restore_carry_o          = state_q.sv_carry;
    assign restore_nop_mode_o       = state_q.sv_nop;
    assign acc_a_o                  = state_q.acc_a;
    assign acc_b_o                  = state_q.acc_b;
    assign prdata_o                 = state_q.rdata;
    assign pready_o                 = 1'b1;
    assign pslverr_o                = psel_i & penable_i & state_q.bus_err;

endmodule : itx_exec

`default_nettype wire

// [itx_exec_properties.sv]
// Assertion checker for the instruction unit ports
`timescale 1ns/100ps
`default_nettype none
module itx_chk import itx_pkg::*; (
    input wire logic                core_clk_i, rst_n_i, instr_valid_i, psel_i, penable_i,
    input wire logic [INSTR_W-1:0]  instr_i,
    input wire logic [ADDR_W-1:0]   paddr_i,
    input wire logic                global_irq_enable_flag_o, skip_o, ret_sub_o, ret_irq_o,
    input wire logic                pready_o, pslverr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Instruction that really executes
    wire go = instr_valid_i && !skip_o;
    ena_set_a: assert property (go && instr_i == OP_IRQ_ENA |=> global_irq_enable_flag_o)
        else $error("enable lost");
    dis_clr_a: assert property (go && instr_i == OP_IRQ_DIS |=> !global_irq_enable_flag_o)
        else $error("disable lost");
    sub_ret_a: assert property (go && instr_i[9:1] == OP_RET_SUB[9:1] |=> ret_sub_o)
        else $error("no return pulse");
    ret_skip_a: assert property (go && instr_i == OP_RET_SUB_SKIP |=> skip_o)
        else $error("no skip after return");
    irq_ret_a: assert property (go && instr_i == OP_RET_IRQ |=> ret_irq_o)
        else $error("no interrupt return");
    skip_eat_a: assert property (instr_valid_i && skip_o |=> !skip_o)
        else $error("skip not consumed");
    skip_hold_a: assert property (skip_o && !instr_valid_i |=> skip_o)
        else $error("skip dropped");
    bus_err_a: assert property (psel_i && penable_i && paddr_i == 8'hfc |-> pslverr_o && pready_o)
        else $error("unmapped not refused");
    // Main scenarios
    cover property (go && instr_i == OP_RET_SUB_SKIP);
    cover property (instr_valid_i && skip_o);
    cover property (psel_i && penable_i && pslverr_o);
endmodule : itx_chk
bind itx_exec itx_chk u_chk (.core_clk_i, .rst_n_i, .instr_valid_i, .psel_i, .penable_i,
    .instr_i, .paddr_i, .global_irq_enable_flag_o, .skip_o, .ret_sub_o, .ret_irq_o,
    .pready_o, .pslverr_o);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the instruction unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import itx_pkg::*;
    logic core_clk_i, rst_n_i, instr_valid_i, irq_entry_i, carry_i, nop_mode_i, pe;
    logic ext0_req_i, ext1_req_i, ext_irq_pin_zero_i, ext_irq_pin_one_i, psel_i, penable_i;
    logic pwrite_i, global_irq_enable_flag_o, skip_o, ret_sub_o, ret_irq_o;
    logic restore_carry_o, restore_nop_mode_o, pready_o, pslverr_o;
    logic [INSTR_W-1:0] instr_i;
    logic [NIB_W-1:0]   dp_x_i, dp_y_i, restore_x_o, restore_y_o, acc_a_o, acc_b_o;
    logic [1:0]         dp_z_i, restore_z_o;
    logic [ADDR_W-1:0]  paddr_i;
    logic [DATA_W-1:0]  pwdata_i, prdata_o, rd;
    logic [INSTR_W-1:0] wo[10] = '{OP_WR_ICTRL1, OP_WR_ICTRL2, OP_WR_ECTRL1, OP_WR_ECTRL2,
        OP_WR_TCTRL1, OP_WR_TCTRL2, OP_WR_TCTRL3, OP_WR_TCTRL4, OP_WR_TCTRL5, OP_WR_TCTRL6};
    logic [INSTR_W-1:0] ro[10] = '{OP_RD_ICTRL1, OP_RD_ICTRL2, OP_RD_ECTRL1, OP_RD_ECTRL2,
        OP_RD_TCTRL1, OP_RD_TCTRL2, OP_RD_TCTRL3, OP_RD_TCTRL4, OP_RD_TCTRL5, OP_RD_TCTRL6};
    int err_count, total_checks, v, tv[5];
    itx_exec dut (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One instruction, effects visible after its edge
    task automatic ex(input logic [9:0] c);
        @(posedge core_clk_i);
        instr_i <= c;
        instr_valid_i <= 1'b1;
        @(posedge core_clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask : ex
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, ad, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        pe = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask : apb
    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Clock and watchdog
    initial
    begin
        core_clk_i = 0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        final_report;
    end
    // Main sequence
    initial
    begin
        {rst_n_i, instr_valid_i, irq_entry_i, carry_i, nop_mode_i, ext0_req_i, ext1_req_i} = 0;
        {ext_irq_pin_zero_i, ext_irq_pin_one_i, psel_i, penable_i, pwrite_i, instr_i} = 0;
        {dp_x_i, dp_y_i, dp_z_i, paddr_i, pwdata_i} = 0;
        v = $urandom(32'h97cf3615);
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        ex(OP_IRQ_ENA);
        chk(global_irq_enable_flag_o, 1);
        ex(OP_IRQ_DIS);
        chk(global_irq_enable_flag_o, 0);
        ex(OP_RET_SUB_SKIP);
        chk({ret_sub_o, skip_o}, 3);
        ex(OP_IRQ_ENA);
        chk({global_irq_enable_flag_o, skip_o}, 0);
        ex(OP_RET_SUB);
        chk({ret_sub_o, skip_o}, 2);
        for (int i = 0; i < 5; i++)
        begin
            tv[i] = $urandom_range(255);
            apb(1, REG_ACC, tv[i]);
            ex(i > 0 ? OP_WR_TIMER_BASE + i - 1 : WRITE_PRESCALER_OP);
            apb(1, REG_ACC, 0);
            ex(i > 0 ? OP_RD_TIMER_BASE + i - 1 : READ_PRESCALER_OP);
            chk({acc_b_o, acc_a_o}, tv[i]);
            apb(0, REG_PRESC + 8'(4 * i), 0);
            chk(rd[15:0], {tv[i][7:0], tv[i][7:0]});
        end
        v = $urandom_range(255);
        apb(1, REG_ACC, v);
        ex(RELOAD_ONLY_WRITE_OP);
        ex(OP_RELOAD_ONLY_T3);
        ex(HIGH_RELOAD_WRITE_OP);
        ex(RELOAD_COPY_OP);
        apb(0, REG_TIMER1, 0);
        chk(rd[15:0], {v[7:0], tv[1][7:0]});
        apb(0, REG_TIMER3, 0);
        chk(rd[15:0], {v[7:0], tv[3][7:0]});
        apb(0, REG_TIMER4, 0);
        chk(rd[23:0], {v[7:0], tv[4][7:0], tv[4][7:0]});
        {ext0_req_i, ext1_req_i} <= 2'b11;
        @(posedge core_clk_i);
        {ext0_req_i, ext1_req_i} <= 2'b00;
        for (int k = 0; k < 2; k++)
        begin
            ex(OP_TST_FLAG0 + 10'(k));
            chk(skip_o, 1);
            repeat (2) ex(OP_TST_FLAG0 + 10'(k));
            chk(skip_o, 0);
        end
        for (int k = 0; k < 8; k++)
        begin
            v = $urandom_range(1);
            apb(1, REG_ACC, k[2] ? 4 : 0);
            {ext_irq_pin_zero_i, ext_irq_pin_one_i} <= {2{v[0]}};
            ex(OP_WR_ECTRL1);
            ex(OP_WR_ECTRL2);
            repeat (3) @(posedge core_clk_i);
            ex(OP_TST_PIN0 + 10'(k % 2));
            chk(skip_o, v[0] == k[2]);
            ex(OP_IRQ_DIS);
        end
        for (int i = 0; i < 10; i++)
        begin
            v = $urandom_range(15);
            apb(1, REG_ACC, v);
            ex(wo[i]);
            ex(OP_WR_PSCTRL);
            apb(1, REG_ACC, 0);
            ex(ro[i]);
            chk(acc_a_o, v);
        end
        apb(0, REG_CTRL, 0);
        chk(rd[19:16], v);
        v = $urandom_range(255);
        apb(1, REG_ACC, v);
        {dp_x_i, dp_y_i, dp_z_i, carry_i, nop_mode_i, irq_entry_i} <= {12'($urandom), 1'b1};
        @(posedge core_clk_i);
        irq_entry_i <= 1'b0;
        apb(1, REG_ACC, ~v);
        ex(OP_RET_IRQ);
        chk({ret_irq_o, restore_x_o, restore_y_o, restore_z_o, restore_carry_o,
            restore_nop_mode_o, acc_b_o, acc_a_o},
            {1'b1, dp_x_i, dp_y_i, dp_z_i, carry_i, nop_mode_i, v[7:0]});
        apb(0, 8'hfc, 0);
        chk({pe, rd[30:0]}, {1'b1, 31'h0});
        final_report;
    end
endmodule : tb_top
`default_nettype wire
